// *** irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC = 6;
    localparam int NUM_VECTORS = 7;
    localparam int NUM_LEVELS = 4;
    localparam int NUM_EVT = 3;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_PRIO_LOW = 8'h01;
    localparam logic [7:0] OFS_PRIO_HIGH = 8'h02;
    localparam logic [7:0] OFS_PENDING = 8'h03;
    localparam logic [7:0] OFS_IN_SERVICE = 8'h04;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h05;
    localparam logic [7:0] OFS_EVT_MASK = 8'h06;

    // ------------------------------------------------------------
    // field positions, shared by enable and both priority registers
    // ------------------------------------------------------------
    localparam int BIT_PIN0 = 0;
    localparam int BIT_TMR0 = 1;
    localparam int BIT_PIN1 = 2;
    localparam int BIT_TMR1 = 3;
    localparam int BIT_SERIAL = 4;
    localparam int BIT_TMR2 = 5;
    localparam int BIT_RSVD = 6;
    localparam int BIT_GLOBAL = 7;

    // event bits of the status and mask registers
    localparam int EVT_ACK = 0;
    localparam int EVT_NEST = 1;
    localparam int EVT_RETURN = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [5:0] RST_PRIO_LOW = 6'h00;
    localparam logic [5:0] RST_PRIO_HIGH = 6'h00;
    localparam logic [2:0] RST_EVT_MASK = 3'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // ------------------------------------------------------------
    // offer handshake towards the core
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OFFER_IDLE = 2'b00,
        OFFER_ACTIVE = 2'b01,
        OFFER_SETTLE = 2'b11
    } offer_state_t;

endpackage : irq_ctrl_pkg

// *** irq_pin_sync.sv ***
`timescale 1ns/100ps
module irq_pin_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // pin and clean level
    input wire logic pin_in,
    output logic level_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ------------------------------------------------------------
    // three stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ------------------------------------------------------------
    // accept a change once stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

endmodule : irq_pin_sync

// *** irq_prio_arbiter.sv ***
`timescale 1ns/100ps
module irq_prio_arbiter (
    // qualified requests and priority bits
    input wire logic [5:0] pend,
    input wire logic [5:0] prio_low,
    input wire logic [5:0] prio_high,
    // winner
    output logic win_valid,
    output logic [2:0] win_idx,
    output logic [1:0] win_lvl
);

    // ------------------------------------------------------------
    // highest level first, lowest bit index first within a level
    // ------------------------------------------------------------
    always_comb begin
        win_valid = 1'b0;
        win_idx = 3'h0;
        win_lvl = 2'h0;
        for (int i = 0; i < irq_ctrl_pkg::NUM_SRC; i++) begin
            if (pend[i] && (!win_valid || {prio_high[i], prio_low[i]} > win_lvl)) begin
                win_valid = 1'b1;
                win_idx = 3'(i);
                win_lvl = {prio_high[i], prio_low[i]};
            end
        end
    end

endmodule : irq_prio_arbiter

// *** irq_priority_ctrl.sv ***
`timescale 1ns/100ps

// Summary of operation
// - seven vectors; two pins, three timer overflows and serial port served
// - each source has its own enable bit; cleared bit blocks service
// - global enable bit; while cleared no source is served
// - with global enable set, each source follows its own enable bit
// - level is high-register bit over low-register bit, 0 lowest, 3 highest
// - higher level preempts lower service; equal level does not preempt
// - a level 3 service is never preempted
// - simultaneous requests of different levels: higher level served first
// - equal level: fixed polling order, lowest bit position wins
// - enable bit 0 gates pin request 0, bit 2 gates pin request 1
// - priority registers use the enable bit positions 0 to 5
// - enable register resets to zero, all interrupts disabled
module irq_priority_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // request sources
    input wire logic ext_request_pin0,
    input wire logic ext_request_pin1,
    input wire logic tmr0_ovf_req,
    input wire logic tmr1_ovf_req,
    input wire logic tmr2_ovf_req,
    input wire logic serial_req,
    // core handshake
    output logic core_irq_req,
    output logic [2:0] core_irq_vector,
    output logic [1:0] core_irq_level,
    input wire logic core_irq_ack,
    input wire logic core_reti,
    // summary interrupt
    output logic sys_irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] irq_enable_reg_q;
    logic [5:0] priority_low_reg_q;
    logic [5:0] priority_high_reg_q;
    logic [2:0] evt_status_q;
    logic [2:0] evt_mask_q;
    logic [3:0] in_service_q;
    logic [3:0] in_service_d;
    logic [7:0] rdata_d;
    logic [1:0] pin_level;
    logic [5:0] raw_req;
    logic [5:0] pend;
    logic global_irq_enable;
    logic win_valid;
    logic [2:0] win_idx;
    logic [1:0] win_lvl;
    logic can_preempt;
    logic offer_ok;
    logic take;
    logic [2:0] evt_set;
    logic [1:0] cur_lvl;
    logic cur_busy;
    irq_ctrl_pkg::offer_state_t offer_q;
    irq_ctrl_pkg::offer_state_t offer_d;
    logic [2:0] vec_q;
    logic [1:0] lvl_q;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = reg_wr && (reg_addr == ofs);
    endfunction : wr_hit

    function automatic logic [2:0] top_level(input logic [3:0] svc);
        top_level = 3'h0;
        for (int i = 0; i < irq_ctrl_pkg::NUM_LEVELS; i++) begin
            if (svc[i]) begin
                top_level = {1'b1, 2'(i)};
            end
        end
    endfunction : top_level

    // ------------------------------------------------------------
    // external pins through synchronisers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            irq_pin_sync u_sync (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .pin_in(g == 0 ? ext_request_pin0 : ext_request_pin1),
                .level_q(pin_level[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // source map and gating
    // ------------------------------------------------------------
    always_comb begin
        raw_req = 6'h00;
        raw_req[irq_ctrl_pkg::BIT_PIN0] = pin_level[0];
        raw_req[irq_ctrl_pkg::BIT_PIN1] = pin_level[1];
        raw_req[irq_ctrl_pkg::BIT_TMR0] = tmr0_ovf_req;
        raw_req[irq_ctrl_pkg::BIT_TMR1] = tmr1_ovf_req;
        raw_req[irq_ctrl_pkg::BIT_TMR2] = tmr2_ovf_req;
        raw_req[irq_ctrl_pkg::BIT_SERIAL] = serial_req;
    end

    assign global_irq_enable = irq_enable_reg_q[irq_ctrl_pkg::BIT_GLOBAL];
    // per-source gate, then global gate
    assign pend = raw_req & irq_enable_reg_q[5:0] & {6{global_irq_enable}};

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    irq_prio_arbiter u_arb (
        .pend(pend),
        .prio_low(priority_low_reg_q),
        .prio_high(priority_high_reg_q),
        .win_valid(win_valid),
        .win_idx(win_idx),
        .win_lvl(win_lvl)
    );

    assign {cur_busy, cur_lvl} = top_level(in_service_q);
    // strictly higher than the running level; level 3 can never exceed
    assign can_preempt = !cur_busy || (win_lvl > cur_lvl);
    assign offer_ok = win_valid && can_preempt;

    // ------------------------------------------------------------
    // offer state machine
    // ------------------------------------------------------------
    assign take = (offer_q == irq_ctrl_pkg::OFFER_ACTIVE) && core_irq_ack;

    always_comb begin
        offer_d = offer_q;
        unique case (offer_q)
            irq_ctrl_pkg::OFFER_IDLE: begin
                if (offer_ok) begin
                    offer_d = irq_ctrl_pkg::OFFER_ACTIVE;
                end
            end
            irq_ctrl_pkg::OFFER_ACTIVE: begin
                if (core_irq_ack) begin
                    offer_d = irq_ctrl_pkg::OFFER_SETTLE;
                end else if (!offer_ok) begin
                    offer_d = irq_ctrl_pkg::OFFER_IDLE;
                end
            end
            irq_ctrl_pkg::OFFER_SETTLE: begin
                offer_d = irq_ctrl_pkg::OFFER_IDLE;
            end
            default: begin
                offer_d = irq_ctrl_pkg::OFFER_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            offer_q <= irq_ctrl_pkg::OFFER_IDLE;
        end else begin
            offer_q <= offer_d;
        end
    end

    // winner tracks arbitration while not being taken
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            vec_q <= 3'h0;
            lvl_q <= 2'h0;
        end else if (!take && offer_ok) begin
            vec_q <= win_idx;
            lvl_q <= win_lvl;
        end
    end

    assign core_irq_req = (offer_q == irq_ctrl_pkg::OFFER_ACTIVE);
    assign core_irq_vector = vec_q;
    assign core_irq_level = lvl_q;

    // ------------------------------------------------------------
    // in-service record
    // ------------------------------------------------------------
    always_comb begin
        in_service_d = in_service_q;
        if (core_reti && cur_busy) begin
            in_service_d[cur_lvl] = 1'b0;
        end
        if (take) begin
            in_service_d[lvl_q] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            in_service_q <= 4'h0;
        end else begin
            in_service_q <= in_service_d;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_enable_reg_q <= irq_ctrl_pkg::RST_ENABLE;
        end else if (wr_hit(irq_ctrl_pkg::OFS_ENABLE)) begin
            irq_enable_reg_q <= reg_wdata;
            irq_enable_reg_q[irq_ctrl_pkg::BIT_RSVD] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            priority_low_reg_q <= irq_ctrl_pkg::RST_PRIO_LOW;
        end else if (wr_hit(irq_ctrl_pkg::OFS_PRIO_LOW)) begin
            priority_low_reg_q <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            priority_high_reg_q <= irq_ctrl_pkg::RST_PRIO_HIGH;
        end else if (wr_hit(irq_ctrl_pkg::OFS_PRIO_HIGH)) begin
            priority_high_reg_q <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evt_mask_q <= irq_ctrl_pkg::RST_EVT_MASK;
        end else if (wr_hit(irq_ctrl_pkg::OFS_EVT_MASK)) begin
            evt_mask_q <= reg_wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // event status, write one to clear, set wins
    // ------------------------------------------------------------
    always_comb begin
        evt_set = 3'h0;
        evt_set[irq_ctrl_pkg::EVT_ACK] = take;
        evt_set[irq_ctrl_pkg::EVT_NEST] = take && cur_busy;
        evt_set[irq_ctrl_pkg::EVT_RETURN] = core_reti && cur_busy;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evt_status_q <= 3'h0;
        end else if (wr_hit(irq_ctrl_pkg::OFS_EVT_STATUS)) begin
            evt_status_q <= (evt_status_q & ~reg_wdata[2:0]) | evt_set;
        end else begin
            evt_status_q <= evt_status_q | evt_set;
        end
    end

    assign sys_irq = |(evt_status_q & evt_mask_q);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            irq_ctrl_pkg::OFS_ENABLE: rdata_d = irq_enable_reg_q;
            irq_ctrl_pkg::OFS_PRIO_LOW: rdata_d = {2'h0, priority_low_reg_q};
            irq_ctrl_pkg::OFS_PRIO_HIGH: rdata_d = {2'h0, priority_high_reg_q};
            irq_ctrl_pkg::OFS_PENDING: rdata_d = {2'h0, pend};
            irq_ctrl_pkg::OFS_IN_SERVICE: rdata_d = {4'h0, in_service_q};
            irq_ctrl_pkg::OFS_EVT_STATUS: rdata_d = {5'h00, evt_status_q};
            irq_ctrl_pkg::OFS_EVT_MASK: rdata_d = {5'h00, evt_mask_q};
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= irq_ctrl_pkg::RST_RDATA;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= irq_ctrl_pkg::RST_RDATA;
        end
    end

endmodule : irq_priority_ctrl

// *** irq_checker_properties.sv ***
`timescale 1ns/100ps
module irq_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // core handshake
    input wire logic core_irq_req,
    input wire logic [2:0] core_irq_vector,
    input wire logic [1:0] core_irq_level,
    input wire logic core_irq_ack,
    input wire logic core_reti,
    input wire logic sys_irq
);
    logic [7:0] en_q, en_p;
    logic [5:0] pl_q, pl_p, ph_q, ph_p;
    logic [2:0] mask_q;
    logic [3:0] isv_q, rel_v, set_v;
    logic [2:0] top;

    // ----------------------------------------
    // shadow of registers and in-service levels
    // ----------------------------------------
    always_comb begin
        top = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (isv_q[i]) top = 3'(i + 1);
        end
        rel_v = (core_reti && top != 3'h0) ? 4'h1 << (top - 3'h1) : 4'h0;
        set_v = (core_irq_req && core_irq_ack) ? 4'h1 << core_irq_level : 4'h0;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {en_q, en_p, pl_q, pl_p, ph_q, ph_p, mask_q} <= '0;
        end else begin
            en_p <= en_q;
            pl_p <= pl_q;
            ph_p <= ph_q;
            if (reg_wr && reg_addr == irq_ctrl_pkg::OFS_ENABLE) en_q <= reg_wdata & 8'hbf;
            if (reg_wr && reg_addr == irq_ctrl_pkg::OFS_PRIO_LOW) pl_q <= reg_wdata[5:0];
            if (reg_wr && reg_addr == irq_ctrl_pkg::OFS_PRIO_HIGH) ph_q <= reg_wdata[5:0];
            if (reg_wr && reg_addr == irq_ctrl_pkg::OFS_EVT_MASK) mask_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) isv_q <= 4'h0;
        else isv_q <= (isv_q & ~rel_v) | set_v;
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_global_gate: assert property (!en_q[7] && !en_p[7] |-> !core_irq_req)
        else $error("offer while global enable off");
    a_source_gate: assert property (core_irq_req |-> en_q[core_irq_vector] || en_p[core_irq_vector])
        else $error("offer of a disabled source");
    a_level_form: assert property (core_irq_req && pl_q == pl_p && ph_q == ph_p
        |-> core_irq_level == {ph_p[core_irq_vector], pl_p[core_irq_vector]})
        else $error("offered level not from priority bits");
    a_no_preempt: assert property (core_irq_req |-> {1'b0, core_irq_level} >= top)
        else $error("offer not above in-service level");
    a_ack_settle: assert property (core_irq_req && core_irq_ack |=> !core_irq_req [*2])
        else $error("offer too soon after accept");
    a_enable_read: assert property (reg_rd && reg_addr == irq_ctrl_pkg::OFS_ENABLE
        |=> reg_rdata == en_q)
        else $error("enable readback wrong");
    a_prio_read: assert property (reg_rd && reg_addr == irq_ctrl_pkg::OFS_PRIO_HIGH
        |=> reg_rdata == {2'b00, ph_q})
        else $error("priority high readback wrong");
    a_reset_quiet: assert property (disable iff (1'b0)
        !rstn |-> !core_irq_req && !sys_irq && reg_rdata == 8'h00)
        else $error("outputs active in reset");
    a_accept_event: assert property (core_irq_req && core_irq_ack && mask_q[0] |=> sys_irq)
        else $error("accept event not signalled");
endmodule : irq_checker

bind irq_priority_ctrl irq_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_irq_req(core_irq_req), .core_irq_vector(core_irq_vector),
    .core_irq_level(core_irq_level), .core_irq_ack(core_irq_ack), .core_reti(core_reti),
    .sys_irq(sys_irq));

// *** irq_core_model.sv ***
`timescale 1ns/100ps
module irq_core_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // offer from the controller
    input wire logic core_irq_req,
    // bench control
    input wire logic [3:0] stall,
    input wire logic reti_go,
    // answers
    output logic core_irq_ack,
    output logic core_reti
);
    logic [3:0] wait_q;

    // accept after stall cycles of a standing offer, return on command
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 4'h0;
            core_irq_ack <= 1'b0;
            core_reti <= 1'b0;
        end else begin
            core_reti <= reti_go;
            core_irq_ack <= 1'b0;
            if (!core_irq_req || core_irq_ack) wait_q <= 4'h0;
            else if (wait_q >= stall) core_irq_ack <= 1'b1;
            else wait_q <= wait_q + 4'h1;
        end
    end
endmodule : irq_core_model

// *** tb.sv ***
`timescale 1ns/100ps
`define CHK(a, e) \
    begin \
        cmp_count++; \
        if ((a) !== (e)) begin \
            n_fail++; \
            $display("wrong value at %0t: got %h exp %h", $time, a, e); \
        end \
    end
module tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, d;
    logic [5:0] src = 6'h00;
    logic core_irq_req, core_irq_ack, core_reti, sys_irq;
    logic [2:0] core_irq_vector;
    logic [1:0] core_irq_level;
    logic [3:0] stall = 4'h5;
    logic reti_go = 1'b0;
    logic [15:0] lfsr_q = 16'd57923;
    int n_fail = 0;
    int cmp_count = 0;
    int en_m, pl_m, ph_m;
    int isv_m[$];

    always #5 clk_sys = ~clk_sys;

    irq_priority_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_request_pin0(src[0]), .tmr0_ovf_req(src[1]), .ext_request_pin1(src[2]),
        .tmr1_ovf_req(src[3]), .serial_req(src[4]), .tmr2_ovf_req(src[5]),
        .core_irq_req(core_irq_req), .core_irq_vector(core_irq_vector),
        .core_irq_level(core_irq_level), .core_irq_ack(core_irq_ack),
        .core_reti(core_reti), .sys_irq(sys_irq));

    irq_core_model core (.clk_sys(clk_sys), .rstn(rstn), .core_irq_req(core_irq_req),
        .stall(stall), .reti_go(reti_go), .core_irq_ack(core_irq_ack), .core_reti(core_reti));

    // ----------------------------------------
    // bus tasks and model
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic cfg(input logic [7:0] en, input logic [7:0] pl, input logic [7:0] ph);
        en_m = en & 8'hbf;
        pl_m = pl & 8'h3f;
        ph_m = ph & 8'h3f;
        wr(irq_ctrl_pkg::OFS_ENABLE, en & 8'hbf);
        wr(irq_ctrl_pkg::OFS_PRIO_LOW, pl);
        wr(irq_ctrl_pkg::OFS_PRIO_HIGH, ph);
    endtask : cfg

    function automatic logic [15:0] lfsr_next(input logic [15:0] q);
        return {q[14:0], q[15] ^ q[13] ^ q[12] ^ q[10]};
    endfunction : lfsr_next

    function automatic int pick(input int rq, input int fl);
        int best;
        int bl;
        int l;
        best = -1;
        bl = -1;
        for (int s = 0; s < 6; s++) begin
            l = 2 * ((ph_m >> s) & 1) + ((pl_m >> s) & 1);
            if (en_m[7] && en_m[s] && rq[s] && l >= fl && l > bl) begin
                best = s;
                bl = l;
            end
        end
        return best;
    endfunction : pick

    task automatic serve(input logic [5:0] rq);
        int e;
        logic got;
        e = pick(rq, isv_m.size() ? isv_m[$] + 1 : 0);
        @(posedge clk_sys);
        src <= rq;
        repeat (20) begin
            @(posedge clk_sys);
            #1 got = core_irq_req && core_irq_ack;
            if (got) break;
        end
        `CHK(got, e >= 0)
        if (got && e >= 0) begin
            `CHK(core_irq_vector, 3'(e))
            `CHK(core_irq_level, 2'(2 * ((ph_m >> e) & 1) + ((pl_m >> e) & 1)))
            isv_m.push_back(2 * ((ph_m >> e) & 1) + ((pl_m >> e) & 1));
        end
        @(posedge clk_sys);
        src <= 6'h00;
    endtask : serve

    task automatic ret();
        repeat (6) @(posedge clk_sys);
        reti_go <= 1'b1;
        @(posedge clk_sys);
        reti_go <= 1'b0;
        if (isv_m.size() > 0) void'(isv_m.pop_back());
        repeat (2) @(posedge clk_sys);
    endtask : ret

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (d[i]) begin
            rd(8'(i));
            `CHK(d, 8'h00)
        end
        rd(8'hff);
        `CHK(d, 8'h00)
        serve(6'h3f);
        for (int s = 0; s < 6; s++) begin
            cfg(8'h3f, 8'h00, 8'h00);
            serve(6'h3f);
            cfg(8'h80 | (8'h3f & ~(8'h1 << s)), 8'h00, 8'h00);
            serve(6'h1 << s);
            cfg(8'h80 | (8'h1 << s), 8'h00, 8'h00);
            serve(6'h3f);
            if (isv_m.size() > 0) ret();
        end
        repeat (30) begin
            lfsr_q = lfsr_next(lfsr_q);
            stall <= 4'h5 + {2'b00, lfsr_q[1:0]};
            cfg(lfsr_q[15:8], lfsr_q[11:4], lfsr_q[7:0]);
            serve(lfsr_q[13:8] ^ lfsr_q[5:0]);
            if (isv_m.size() > 0) ret();
        end
        stall <= 4'h0;
        cfg(8'hbf, 8'h32, 8'h28);
        serve(6'h02);
        serve(6'h10);
        serve(6'h08);
        serve(6'h20);
        serve(6'h08);
        rd(irq_ctrl_pkg::OFS_IN_SERVICE);
        `CHK(d, 8'h0e)
        `CHK(sys_irq, 1'b0)
        wr(irq_ctrl_pkg::OFS_EVT_MASK, 8'h03);
        #1 `CHK(sys_irq, 1'b1)
        rd(irq_ctrl_pkg::OFS_EVT_STATUS);
        `CHK(d, 8'h07)
        wr(irq_ctrl_pkg::OFS_EVT_STATUS, 8'h07);
        repeat (3) ret();
        rd(irq_ctrl_pkg::OFS_IN_SERVICE);
        `CHK(d, 8'h00)
        `CHK(sys_irq, 1'b0)
        serve(6'h02);
        #1 `CHK(sys_irq, 1'b1)
        final_report();
    end

    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule : tb
